// [verilog/pmi_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pmi_top (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire pmi_pkg::pmi_req_t REQ_I,
	input wire logic REQ_VALID_I,
	output logic REQ_READY_O,
	input wire logic [31:0] WR_DATA_I,
	input wire logic WR_VALID_I,
	output logic WR_READY_O,
	output logic [31:0] RD_DATA_O,
	output logic RD_VALID_O,
	input wire logic RD_READY_I,
	output logic DONE_O,
	output logic ABORT_O,
	input wire logic GNT_N_I,
	output logic REQ_N_O,
	input wire logic [31:0] AD_I,
	output logic [31:0] AD_O,
	output logic AD_OE_N_O,
	input wire logic [3:0] CBE_I,
	output logic [3:0] CBE_O,
	output logic CBE_OE_N_O,
	input wire logic FRAME_N_I,
	output logic FRAME_N_O,
	output logic FRAME_OE_N_O,
	input wire logic IRDY_N_I,
	output logic IRDY_N_O,
	output logic IRDY_OE_N_O,
	input wire logic TRDY_N_I,
	input wire logic DEVSEL_N_I,
	input wire logic IDSEL_I,
	output logic CFG_HIT_O,
	output logic CFG_WR_O,
	input wire logic [pmi_pkg::IRQ_W-1:0] EVENT_I,
	input wire logic [pmi_pkg::IRQ_W-1:0] MASK_I,
	input wire logic [pmi_pkg::IRQ_W-1:0] CLEAR_I,
	output logic [pmi_pkg::IRQ_W-1:0] STATUS_O,
	output logic INT_N_O,
	output logic INT_OE_N_O
);
	pmi_pkg::pmi_state_t st_ff, nxt_st;
	logic [31:0] addr_ff, nxt_addr, ad_ff, nxt_ad;
	logic [7:0] rem_ff, nxt_rem;
	logic is_wr_ff, nxt_is_wr;
	logic frame_n_ff, nxt_frame_n, irdy_n_ff, nxt_irdy_n, oe_n_ff, nxt_oe_n, ad_oe_n_ff, nxt_ad_oe_n;
	logic [3:0] cbe_ff, nxt_cbe;
	logic req_n_ff, nxt_req_n, req_ready_ff, nxt_req_ready, wr_ready_ff, nxt_wr_ready;
	logic done_ff, nxt_done, abort_ff, nxt_abort;
	logic [2:0] dcnt_ff;
	logic claimed_ff, timeout, complete, push, pop, load, read_room;
	logic [1:0] cnt_next;
	logic v0_ff, v1_ff;
	logic [31:0] d0_ff, d1_ff;
	logic frame_prev_ff, cfg_hit_ff, cfg_wr_ff, addr_phase;
	logic [pmi_pkg::IRQ_W-1:0] status_ff, nxt_status;
	logic int_on_ff, pend_next, clr_any, partial;

	// all output pins except the tied-low INT_N_O are registered on the rising edge only; input pins are used unregistered
	assign complete = (st_ff == pmi_pkg::ST_DATA) && !irdy_n_ff && !TRDY_N_I && !DEVSEL_N_I;
	assign push = complete && !is_wr_ff;
	assign pop = v0_ff && RD_READY_I;
	assign load = wr_ready_ff && WR_VALID_I;
	assign cnt_next = {1'b0, v0_ff} + {1'b0, v1_ff} + {1'b0, push} - {1'b0, pop};
	assign read_room = (cnt_next != 2'h2);
	assign timeout = (st_ff == pmi_pkg::ST_DATA) && !claimed_ff && DEVSEL_N_I
		&& (dcnt_ff == pmi_pkg::DEVSEL_LIMIT - 3'h1);

	always_comb begin
		nxt_st = st_ff;
		nxt_addr = addr_ff;
		nxt_ad = ad_ff;
		nxt_rem = rem_ff;
		nxt_is_wr = is_wr_ff;
		nxt_frame_n = frame_n_ff;
		nxt_irdy_n = irdy_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_ad_oe_n = ad_oe_n_ff;
		nxt_cbe = cbe_ff;
		nxt_req_n = req_n_ff;
		nxt_req_ready = req_ready_ff;
		nxt_wr_ready = wr_ready_ff;
		nxt_done = 1'b0;
		nxt_abort = 1'b0;
		case (st_ff)
			pmi_pkg::ST_IDLE: begin
				if (REQ_VALID_I && req_ready_ff) begin
					nxt_addr = REQ_I.addr;
					nxt_is_wr = REQ_I.write;
					nxt_rem = (REQ_I.len == 8'h00) ? pmi_pkg::LEN_MIN : REQ_I.len;
					nxt_req_ready = 1'b0;
					nxt_req_n = 1'b0;
					nxt_st = pmi_pkg::ST_REQ;
				end
			end
			pmi_pkg::ST_REQ: begin
				// wait for grant and an idle bus before taking the pins
				if (!GNT_N_I && FRAME_N_I && IRDY_N_I) begin
					nxt_frame_n = 1'b0;
					nxt_irdy_n = 1'b1;
					nxt_oe_n = 1'b0;
					nxt_ad_oe_n = 1'b0;
					nxt_ad = addr_ff;
					nxt_cbe = is_wr_ff ? pmi_pkg::CMD_MEM_WR : pmi_pkg::CMD_MEM_RD;
					nxt_req_n = 1'b1;
					nxt_st = pmi_pkg::ST_ADDR;
				end
			end
			pmi_pkg::ST_ADDR: begin
				nxt_cbe = pmi_pkg::BE_ALL;
				nxt_st = pmi_pkg::ST_DATA;
				if (is_wr_ff) begin
					nxt_wr_ready = 1'b1;
				end else begin
					// turnaround: the target drives the lines from here
					nxt_ad_oe_n = 1'b1;
					if (read_room) begin
						nxt_irdy_n = 1'b0;
						nxt_frame_n = (rem_ff == 8'h01);
					end
				end
			end
			pmi_pkg::ST_DATA: begin
				if (timeout) begin
					nxt_frame_n = 1'b1;
					nxt_irdy_n = 1'b0;
					nxt_wr_ready = 1'b0;
					nxt_abort = 1'b1;
					nxt_st = pmi_pkg::ST_ABORT;
				end else if (complete) begin
					if (rem_ff == 8'h01) begin
						nxt_irdy_n = 1'b1;
						nxt_done = 1'b1;
						nxt_st = pmi_pkg::ST_TURN;
					end else begin
						nxt_rem = rem_ff - 8'h01;
						if (is_wr_ff) begin
							nxt_irdy_n = 1'b1;
							nxt_wr_ready = 1'b1;
						end else begin
							nxt_irdy_n = !read_room;
							nxt_frame_n = read_room && (rem_ff == 8'h02);
						end
					end
				end else if (load) begin
					nxt_ad = WR_DATA_I;
					nxt_irdy_n = 1'b0;
					nxt_wr_ready = 1'b0;
					nxt_frame_n = (rem_ff == 8'h01);
				end else if (!is_wr_ff && irdy_n_ff && read_room) begin
					nxt_irdy_n = 1'b0;
					nxt_frame_n = (rem_ff == 8'h01);
				end
			end
			pmi_pkg::ST_ABORT: begin
				nxt_irdy_n = 1'b1;
				nxt_st = pmi_pkg::ST_TURN;
			end
			pmi_pkg::ST_TURN: begin
				// pins were driven high for one cycle, now released
				nxt_oe_n = 1'b1;
				nxt_ad_oe_n = 1'b1;
				nxt_req_ready = 1'b1;
				nxt_st = pmi_pkg::ST_IDLE;
			end
			default: begin
				nxt_st = pmi_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			st_ff <= pmi_pkg::ST_IDLE;
			addr_ff <= pmi_pkg::AD_RST;
			ad_ff <= pmi_pkg::AD_RST;
			rem_ff <= 8'h00;
			is_wr_ff <= 1'b0;
			frame_n_ff <= 1'b1;
			irdy_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			ad_oe_n_ff <= 1'b1;
			cbe_ff <= pmi_pkg::BE_ALL;
			req_n_ff <= 1'b1;
			req_ready_ff <= 1'b1;
			wr_ready_ff <= 1'b0;
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			addr_ff <= nxt_addr;
			ad_ff <= nxt_ad;
			rem_ff <= nxt_rem;
			is_wr_ff <= nxt_is_wr;
			frame_n_ff <= nxt_frame_n;
			irdy_n_ff <= nxt_irdy_n;
			oe_n_ff <= nxt_oe_n;
			ad_oe_n_ff <= nxt_ad_oe_n;
			cbe_ff <= nxt_cbe;
			req_n_ff <= nxt_req_n;
			req_ready_ff <= nxt_req_ready;
			wr_ready_ff <= nxt_wr_ready;
			done_ff <= nxt_done;
			abort_ff <= nxt_abort;
		end
	end

	// target claim watchdog, restarted by every address phase
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I || st_ff == pmi_pkg::ST_ADDR) begin
			dcnt_ff <= 3'h0;
			claimed_ff <= 1'b0;
		end else if (st_ff == pmi_pkg::ST_DATA && !claimed_ff) begin
			dcnt_ff <= dcnt_ff + 3'h1;
			claimed_ff <= !DEVSEL_N_I;
		end
	end

	// two-entry read buffer: slot 0 faces the user, so a stall never drops a completed phase
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			v0_ff <= 1'b0;
			v1_ff <= 1'b0;
			d0_ff <= pmi_pkg::AD_RST;
			d1_ff <= pmi_pkg::AD_RST;
		end else if (pop) begin
			if (v1_ff) begin
				d0_ff <= d1_ff;
				v1_ff <= push;
				d1_ff <= AD_I;
			end else begin
				v0_ff <= push;
				d0_ff <= AD_I;
			end
		end else if (push) begin
			if (!v0_ff) begin
				v0_ff <= 1'b1;
				d0_ff <= AD_I;
			end else begin
				v1_ff <= 1'b1;
				d1_ff <= AD_I;
			end
		end
	end

	// configuration access seen as target
	assign addr_phase = !FRAME_N_I && frame_prev_ff;
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			frame_prev_ff <= 1'b1;
			cfg_hit_ff <= 1'b0;
			cfg_wr_ff <= 1'b0;
		end else begin
			frame_prev_ff <= FRAME_N_I;
			cfg_hit_ff <= addr_phase && IDSEL_I && (CBE_I[3:1] == pmi_pkg::CMD_CFG_HI);
			cfg_wr_ff <= CBE_I[0];
		end
	end

	// set wins over a clear arriving in the same cycle
	assign nxt_status = (status_ff & ~CLEAR_I) | EVENT_I;
	assign pend_next = |(nxt_status & ~MASK_I);
	assign clr_any = |(CLEAR_I & status_ff);
	assign partial = clr_any && pend_next;
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			status_ff <= pmi_pkg::STATUS_RST;
			int_on_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			int_on_ff <= pend_next && !partial;
		end
	end

	assign REQ_READY_O = req_ready_ff;
	assign WR_READY_O = wr_ready_ff;
	assign RD_DATA_O = d0_ff;
	assign RD_VALID_O = v0_ff;
	assign DONE_O = done_ff;
	assign ABORT_O = abort_ff;
	assign REQ_N_O = req_n_ff;
	assign AD_O = ad_ff;
	assign AD_OE_N_O = ad_oe_n_ff;
	assign CBE_O = cbe_ff;
	assign CBE_OE_N_O = oe_n_ff;
	assign FRAME_N_O = frame_n_ff;
	assign FRAME_OE_N_O = oe_n_ff;
	assign IRDY_N_O = irdy_n_ff;
	assign IRDY_OE_N_O = oe_n_ff;
	assign CFG_HIT_O = cfg_hit_ff;
	assign CFG_WR_O = cfg_wr_ff;
	assign STATUS_O = status_ff;
	// the pin level never goes high from here; the board pull-up does that
	assign INT_N_O = 1'b0;
	assign INT_OE_N_O = !int_on_ff;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence grant_seen_s;
		st_ff == pmi_pkg::ST_REQ && !GNT_N_I && FRAME_N_I && IRDY_N_I;
	endsequence
	sequence unclaimed_s;
		st_ff == pmi_pkg::ST_ADDR ##1 (DEVSEL_N_I && st_ff == pmi_pkg::ST_DATA)[*5];
	endsequence

	frame_start_a: assert property (grant_seen_s |=> !FRAME_N_O && !FRAME_OE_N_O && REQ_N_O) else $error("frame not started on grant");
	frame_last_a: assert property ($rose(FRAME_N_O) && st_ff == pmi_pkg::ST_DATA |-> !IRDY_N_O && rem_ff == 8'h01) else $error("frame released early");
	grant_first_a: assert property ($fell(FRAME_N_O) |-> $past(!GNT_N_I)) else $error("frame without grant");
	cfg_hit_a: assert property (addr_phase && IDSEL_I && CBE_I[3:1] == pmi_pkg::CMD_CFG_HI |=> CFG_HIT_O) else $error("config access missed");
	irq_assert_a: assert property (pend_next && !partial |=> !INT_OE_N_O) else $error("interrupt not asserted");
	irq_release_a: assert property (!pend_next |=> INT_OE_N_O) else $error("interrupt not released");
	irq_edge_a: assert property (partial ##1 (!clr_any && pend_next) |-> INT_OE_N_O ##1 !INT_OE_N_O) else $error("no edge on partial clear");
	phase_done_a: assert property (!IRDY_N_O && !TRDY_N_I && !DEVSEL_N_I && st_ff == pmi_pkg::ST_DATA && !is_wr_ff |=> RD_VALID_O) else $error("read word lost");
	write_valid_a: assert property ($fell(IRDY_N_O) && is_wr_ff && st_ff == pmi_pkg::ST_DATA |-> !AD_OE_N_O && AD_O == $past(WR_DATA_I) && $past(load)) else $error("write ready without data");
	read_room_a: assert property (!IRDY_N_O && st_ff == pmi_pkg::ST_DATA && !is_wr_ff |-> !(v0_ff && v1_ff)) else $error("read ready while full");
	devsel_abort_a: assert property (unclaimed_s |=> st_ff == pmi_pkg::ST_ABORT && FRAME_N_O && ABORT_O) else $error("no master abort");
	bus_request_a: assert property (st_ff == pmi_pkg::ST_REQ |-> !REQ_N_O) else $error("request pin idle while waiting");
	int_drain_a: assert property (!INT_N_O && (INT_OE_N_O == !int_on_ff)) else $error("interrupt pin driven high");
endmodule : pmi_top
`default_nettype wire

// [inc/pmi_pkg.sv]
`default_nettype none
package pmi_pkg;
	localparam int IRQ_W = 8;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [2:0] CMD_CFG_HI = 3'h5;
	localparam logic [3:0] BE_ALL = 4'h0;
	localparam logic [2:0] DEVSEL_LIMIT = 3'h5;
	localparam logic [7:0] LEN_MIN = 8'h01;
	localparam logic [31:0] AD_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] STATUS_RST = 8'h00;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic [7:0] len;
	} pmi_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_REQ = 3'h1,
		ST_ADDR = 3'h2,
		ST_DATA = 3'h3,
		ST_ABORT = 3'h4,
		ST_TURN = 3'h5
	} pmi_state_t;
endpackage : pmi_pkg
`default_nettype wire

// [verification/pmi_tgt_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pmi_tgt_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_n_i,
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic [31:0] ad_i,
	input wire logic [3:0] cbe_i,
	input wire logic claim_i,
	input wire logic slow_i,
	output logic gnt_n_o,
	output logic trdy_n_o,
	output logic devsel_n_o,
	output logic [31:0] ad_o
);
	logic [31:0] mem [16];
	logic busy;
	logic wr;
	logic [3:0] idx;
	// undriven read lines show the inverse, so a stale word never passes for data
	assign ad_o = (busy && !wr && !devsel_n_o) ? mem[idx] : ~mem[idx];
	always @(posedge clk_i) begin
		gnt_n_o <= rst_i | req_n_i;
		if (rst_i) for (int i = 0; i < 16; i++) mem[i] <= 32'h5a5a_0000 + i;
		if (rst_i || (busy && frame_n_i && irdy_n_i)) begin
			busy <= 1'b0;
			devsel_n_o <= 1'b1;
			trdy_n_o <= 1'b1;
		end else if (!busy && !frame_n_i && cbe_i[3:1] == 3'h3) begin
			busy <= 1'b1;
			wr <= cbe_i[0];
			idx <= ad_i[5:2];
			devsel_n_o <= ~claim_i;
		end else if (busy) begin
			// slow mode drops TRDY for one cycle after every cycle it is asserted
			trdy_n_o <= ~claim_i | (slow_i & ~trdy_n_o);
			if (!irdy_n_i && !trdy_n_o && !devsel_n_o) begin
				if (wr) mem[idx] <= ad_i;
				idx <= idx + 4'h1;
				if (frame_n_i) begin
					busy <= 1'b0;
					devsel_n_o <= 1'b1;
					trdy_n_o <= 1'b1;
				end
			end
		end
	end
endmodule : pmi_tgt_model
`default_nettype wire

// [verification/pci_master_and_interrupt_pins_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module pci_master_and_interrupt_pins_bench;
	logic CLK_I = 0, SYS_RST_I = 1, REQ_VALID_I = 0, WR_VALID_I = 0, RD_READY_I = 0, IDSEL_I = 0;
	pmi_pkg::pmi_req_t REQ_I = '0;
	logic [31:0] WR_DATA_I = '0, AD_I, AD_O, RD_DATA_O, tgt_ad;
	logic [7:0] EVENT_I = '0, MASK_I = '0, CLEAR_I = '0, STATUS_O;
	logic [3:0] CBE_I, CBE_O, host_cbe = '0;
	logic REQ_READY_O, WR_READY_O, RD_VALID_O, DONE_O, ABORT_O, GNT_N_I, REQ_N_O, AD_OE_N_O, CBE_OE_N_O;
	logic FRAME_N_I, FRAME_N_O, FRAME_OE_N_O, IRDY_N_I, IRDY_N_O, IRDY_OE_N_O, TRDY_N_I, DEVSEL_N_I;
	logic CFG_HIT_O, CFG_WR_O, INT_N_O, INT_OE_N_O, host_frame_n = 1, claim = 1, slow = 0;
	int miscompares = 0, checked = 0, cycles = 0;
	// released IRDY floats to the pull-up level; released FRAME, C/BE and AD take the host or target values
	assign FRAME_N_I = FRAME_OE_N_O ? host_frame_n : FRAME_N_O;
	assign IRDY_N_I = IRDY_OE_N_O ? 1'b1 : IRDY_N_O;
	assign CBE_I = CBE_OE_N_O ? host_cbe : CBE_O;
	assign AD_I = AD_OE_N_O ? tgt_ad : AD_O;
	always #12.5 CLK_I = ~CLK_I;
	pmi_top uut (.*);
	pmi_tgt_model tgt (.clk_i(CLK_I), .rst_i(SYS_RST_I), .req_n_i(REQ_N_O), .frame_n_i(FRAME_N_I),
		.irdy_n_i(IRDY_N_I), .ad_i(AD_I), .cbe_i(CBE_I), .claim_i(claim), .slow_i(slow),
		.gnt_n_o(GNT_N_I), .trdy_n_o(TRDY_N_I), .devsel_n_o(DEVSEL_N_I), .ad_o(tgt_ad));
	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	always @(posedge CLK_I) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			end_sim;
		end
	end
	task issue(input logic [31:0] a, input logic w, input logic [7:0] n);
		@(negedge CLK_I);
		REQ_I = '{addr: a, write: w, len: n};
		REQ_VALID_I = 1;
		do @(posedge CLK_I); while (REQ_READY_O !== 1'b1);
		@(negedge CLK_I);
		REQ_VALID_I = 0;
		chk(REQ_N_O === 1'b0 && FRAME_OE_N_O === 1'b1, "bus taken before grant");
	endtask : issue
	task wait_end(output int n);
		n = 0;
		do begin
			@(posedge CLK_I);
			n++;
		end while (DONE_O !== 1'b1 && ABORT_O !== 1'b1 && n < 80);
	endtask : wait_end
	task t_write;
		int n;
		@(negedge CLK_I);
		slow = 1;
		issue(32'h0, 1'b1, 8'h02);
		for (int i = 0; i < 2; i++) begin
			WR_DATA_I = 32'hc0de_0000 + i;
			WR_VALID_I = 1;
			do @(posedge CLK_I); while (WR_READY_O !== 1'b1);
			@(negedge CLK_I);
			chk(IRDY_N_O === 1'b0 && AD_O === WR_DATA_I && CBE_O === 4'h0 && FRAME_N_O === (i == 1), "write phase wrong");
		end
		WR_VALID_I = 0;
		wait_end(n);
		chk(DONE_O === 1'b1, "write burst did not end");
		for (int i = 0; i < 2; i++) chk(tgt.mem[i] === 32'hc0de_0000 + i, "write word lost");
	endtask : t_write
	task t_read;
		int got;
		@(negedge CLK_I);
		slow = 0;
		issue(32'h20, 1'b0, 8'h03);
		got = 0;
		// the receiver stalls long enough to fill both buffer slots
		for (int c = 0; c < 60 && got < 3; c++) begin
			@(posedge CLK_I);
			if (RD_VALID_O === 1'b1 && RD_READY_I) begin
				chk(RD_DATA_O === 32'h5a5a_0008 + got, "read word wrong");
				got++;
			end
			@(negedge CLK_I);
			if (c == 8) chk(IRDY_N_O === 1'b1 && FRAME_N_O === 1'b0, "read ready while buffer full");
			RD_READY_I = c > 8;
		end
		chk(got == 3, "read burst short");
		RD_READY_I = 0;
	endtask : t_read
	task t_abort;
		int n;
		@(negedge CLK_I);
		claim = 0;
		issue(32'h40, 1'b0, 8'h01);
		do @(posedge CLK_I); while (FRAME_N_O !== 1'b0 || FRAME_OE_N_O !== 1'b0);
		wait_end(n);
		chk(ABORT_O === 1'b1 && n >= 5 && n <= 8, "no abort after claim window");
		@(negedge CLK_I);
		claim = 1;
	endtask : t_abort
	task t_cfg;
		for (int k = 0; k < 3; k++) begin
			@(negedge CLK_I);
			host_frame_n = 0;
			host_cbe = k[0] ? 4'hb : 4'ha;
			IDSEL_I = k < 2;
			@(negedge CLK_I);
			host_frame_n = 1;
			IDSEL_I = 0;
			chk(CFG_HIT_O === (k < 2) && (k == 2 || CFG_WR_O === k[0]), "config access misjudged");
		end
	endtask : t_cfg
	task t_irq;
		@(negedge CLK_I);
		EVENT_I = 8'h03;
		@(negedge CLK_I);
		EVENT_I = 8'h00;
		chk(STATUS_O === 8'h03 && INT_OE_N_O === 1'b0 && INT_N_O === 1'b0, "interrupt not raised");
		CLEAR_I = 8'h01;
		@(negedge CLK_I);
		CLEAR_I = 8'h00;
		chk(INT_OE_N_O === 1'b1 && STATUS_O === 8'h02, "no release on partial clear");
		@(negedge CLK_I);
		chk(INT_OE_N_O === 1'b0, "interrupt not reasserted");
		CLEAR_I = 8'h02;
		MASK_I = 8'h04;
		EVENT_I = 8'h04;
		@(negedge CLK_I);
		CLEAR_I = 8'h00;
		EVENT_I = 8'h00;
		chk(STATUS_O === 8'h04 && INT_OE_N_O === 1'b1, "masked cause drives pin");
		MASK_I = 8'h00;
		@(negedge CLK_I);
		chk(INT_OE_N_O === 1'b0, "unmasked cause ignored");
		CLEAR_I = 8'h04;
		@(negedge CLK_I);
		CLEAR_I = 8'h00;
		chk(INT_OE_N_O === 1'b1 && STATUS_O === 8'h00, "pin held after full clear");
	endtask : t_irq
	initial begin
		repeat (8) @(negedge CLK_I);
		chk(REQ_READY_O === 1'b1 && REQ_N_O === 1'b1 && AD_OE_N_O === 1'b1 && INT_OE_N_O === 1'b1, "reset state");
		SYS_RST_I = 0;
		t_write;
		t_read;
		t_abort;
		t_cfg;
		t_irq;
		repeat (4) @(negedge CLK_I);
		end_sim;
	end
endmodule : pci_master_and_interrupt_pins_bench
`default_nettype wire
